// [inc/crf_defines.svh]
`ifndef CRF_DEFINES_SVH
`define CRF_DEFINES_SVH

// Register bus addresses
`define CRF_ADDR_D0 4'h0
`define CRF_ADDR_D1 4'h1
`define CRF_ADDR_D2 4'h2
`define CRF_ADDR_D3 4'h3
`define CRF_ADDR_A0 4'h4
`define CRF_ADDR_A1 4'h5
`define CRF_ADDR_FB 4'h6
`define CRF_ADDR_PC 4'h8
`define CRF_ADDR_VECTOR_TABLE_BASE 4'h9
`define CRF_ADDR_USP 4'hA
`define CRF_ADDR_ISP 4'hB
`define CRF_ADDR_SB 4'hC
`define CRF_ADDR_SP 4'hD
`define CRF_ADDR_FLG 4'hE

// Status word fields
`define CRF_FLG_W 11
`define CRF_F_C 0
`define CRF_F_D 1
`define CRF_F_Z 2
`define CRF_F_S 3
`define CRF_F_B 4
`define CRF_F_O 5
`define CRF_F_I 6
`define CRF_F_U 7
`define CRF_F_IPL_LO 8
`define CRF_F_IPL_HI 10

// Widths, reset values and trap number limit
`define CRF_PC_W 20
`define CRF_FLG_RST 11'h000
`define CRF_PC_RST 20'h00000
`define CRF_WORD_RST 16'h0000
`define CRF_TRAP_U_LIMIT 6'h20
`endif

// [inc/crf_pkg.sv]
`include "crf_defines.svh"
package crf_pkg;
   typedef enum logic [3:0] {
      CRF_D0 = `CRF_ADDR_D0,
      CRF_D1 = `CRF_ADDR_D1,
      CRF_D2 = `CRF_ADDR_D2,
      CRF_D3 = `CRF_ADDR_D3,
      CRF_A0 = `CRF_ADDR_A0,
      CRF_A1 = `CRF_ADDR_A1,
      CRF_FB = `CRF_ADDR_FB,
      CRF_PC = `CRF_ADDR_PC,
      CRF_VECTOR_TABLE_BASE = `CRF_ADDR_VECTOR_TABLE_BASE,
      CRF_USP = `CRF_ADDR_USP,
      CRF_ISP = `CRF_ADDR_ISP,
      CRF_SB = `CRF_ADDR_SB,
      CRF_SP = `CRF_ADDR_SP,
      CRF_FLG = `CRF_ADDR_FLG
   } crf_sel_e;

   typedef enum logic [1:0] {
      CRF_SZ_LO = 2'h0,
      CRF_SZ_HI = 2'h1,
      CRF_SZ_WORD = 2'h2,
      CRF_SZ_LONG = 2'h3
   } crf_size_e;

   typedef struct packed {
      logic en;
      crf_sel_e sel;
      crf_size_e size;
      logic [31:0] data;
   } crf_acc_s;

   typedef struct packed {
      logic valid;
      logic carry;
      logic ovf;
      crf_size_e size;
      logic [31:0] result;
   } crf_alu_s;

   typedef struct packed {
      logic req;
      logic maskable;
      logic [2:0] prio;
   } crf_irq_s;
endpackage : crf_pkg

// [hw/crf_bank_mem.sv]
`timescale 1ns/1ps
module crf_bank_mem #(
   parameter int DW = 16,
   parameter int AW = 4,
   parameter int RP = 2
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Byte-lane write port
   input wire logic wa_en,
   input wire logic [AW-1:0] wa_addr,
   input wire logic [DW-1:0] wa_data,
   input wire logic [1:0] wa_be,
   // Upper-half write port for pairs
   input wire logic wb_en,
   input wire logic [AW-1:0] wb_addr,
   input wire logic [DW-1:0] wb_data,
   // Read ports
   input wire logic [RP-1:0][AW-1:0] rlo_addr,
   input wire logic [RP-1:0][AW-1:0] rhi_addr,
   output logic [RP-1:0][2*DW-1:0] rdata
);
   localparam int HW = DW / 2;
   logic [DW-1:0] mem_q [2**AW];

   always_ff @(posedge clock) begin
      if (reset) begin
         for (int k = 0; k < 2**AW; k++) begin
            mem_q[k] <= '0;
         end
      end else begin
         if (wa_en && wa_be[0]) begin
            mem_q[wa_addr][HW-1:0] <= wa_data[HW-1:0];
         end
         if (wa_en && wa_be[1]) begin
            mem_q[wa_addr][DW-1:HW] <= wa_data[DW-1:HW];
         end
         if (wb_en) begin
            mem_q[wb_addr] <= wb_data;
         end
      end
   end

   for (genvar i = 0; i < RP; i++) begin : g_rd
      always_ff @(posedge clock) begin
         if (reset) begin
            rdata[i] <= '0;
         end else begin
            rdata[i] <= {mem_q[rhi_addr[i]], mem_q[rlo_addr[i]]};
         end
      end
   end
endmodule : crf_bank_mem

// [hw/crf_regfile.sv]
`timescale 1ns/1ps
`include "crf_defines.svh"
module crf_regfile
   import crf_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Register bus
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Execution datapath
   input crf_acc_s dp_wr,
   input crf_acc_s dp_rd,
   output logic [31:0] dp_rdata,
   input crf_alu_s alu,
   // Interrupt acceptance
   input crf_irq_s irq,
   input wire logic int_accept,
   input wire logic trap_exec,
   input wire logic [5:0] trap_num,
   output logic irq_allow,
   output logic [`CRF_FLG_W-1:0] status_word
);
   localparam int NRD = 2;

   logic [`CRF_PC_W-1:0] pc_q;
   logic [`CRF_PC_W-1:0] vector_table_base_q;
   logic [15:0] usp_q;
   logic [15:0] isp_q;
   logic [15:0] sb_q;
   logic [`CRF_FLG_W-1:0] flg_q;
   logic [`CRF_FLG_W-1:0] flg_d;
   logic irq_allow_q;
   crf_acc_s [NRD-1:0] rq;
   crf_acc_s [NRD-1:0] rq_q;
   logic [NRD-1:0][31:0] other_q;
   logic [NRD-1:0][31:0] rd_shaped;
   logic [NRD-1:0][3:0] rlo_addr;
   logic [NRD-1:0][3:0] rhi_addr;
   logic [NRD-1:0][31:0] mem_rd;

   function automatic logic is_banked(input crf_sel_e sel);
      return sel inside {CRF_D0, CRF_D1, CRF_D2, CRF_D3, CRF_A0, CRF_A1, CRF_FB};
   endfunction : is_banked

   function automatic logic is_pair(input crf_sel_e sel, input crf_size_e size);
      return (size == CRF_SZ_LONG) && (sel inside {CRF_D0, CRF_D1, CRF_A0});
   endfunction : is_pair

   function automatic crf_sel_e pair_hi(input crf_sel_e sel);
      return (sel == CRF_A0) ? CRF_A1 : (sel == CRF_D0) ? CRF_D2 : CRF_D3;
   endfunction : pair_hi

   // Status bits
   wire bank = flg_q[`CRF_F_B];
   wire use_usp = flg_q[`CRF_F_U];
   wire int_en = flg_q[`CRF_F_I];
   wire [2:0] processor_priority_level = flg_q[`CRF_F_IPL_HI:`CRF_F_IPL_LO];

   // Bus decode, datapath wins a write collision
   wire bus_hit = is_banked(crf_sel_e'(reg_addr)) ||
      (reg_addr >= `CRF_ADDR_PC && reg_addr <= `CRF_ADDR_FLG);
   crf_acc_s bus_w;
   crf_acc_s w;
   assign bus_w = '{en: reg_wr && bus_hit, sel: crf_sel_e'(reg_addr),
                    size: CRF_SZ_WORD, data: reg_wdata};
   assign w = dp_wr.en ? dp_wr : bus_w;
   assign rq[0] = '{en: reg_rd && bus_hit, sel: crf_sel_e'(reg_addr),
                    size: CRF_SZ_WORD, data: 32'h0000_0000};
   assign rq[1] = dp_rd;

   // Banked write decode
   wire wa_en = w.en && is_banked(w.sel);
   wire [3:0] wa_addr = {bank, w.sel[2:0]};
   wire [15:0] wa_data = (w.size == CRF_SZ_HI) ? {w.data[7:0], w.data[7:0]} : w.data[15:0];
   wire [1:0] wa_be = (w.size == CRF_SZ_LO) ? 2'h1 :
                      (w.size == CRF_SZ_HI) ? 2'h2 : 2'h3;
   wire wb_en = wa_en && is_pair(w.sel, w.size);
   crf_sel_e wb_sel;
   assign wb_sel = pair_hi(w.sel);
   wire [3:0] wb_addr = {bank, wb_sel[2:0]};

   // Non-banked write decode
   wire w_pc = w.en && (w.sel == CRF_PC);
   wire w_vector_table_base = w.en && (w.sel == CRF_VECTOR_TABLE_BASE);
   wire w_sb = w.en && (w.sel == CRF_SB);
   wire w_flg = w.en && (w.sel == CRF_FLG);
   wire w_usp = w.en && ((w.sel == CRF_USP) || (w.sel == CRF_SP && use_usp));
   wire w_isp = w.en && ((w.sel == CRF_ISP) || (w.sel == CRF_SP && !use_usp));

   crf_bank_mem #(
      .DW(16),
      .AW(4),
      .RP(NRD)
   ) u_mem (
      .clock(clock),
      .reset(reset),
      .wa_en(wa_en),
      .wa_addr(wa_addr),
      .wa_data(wa_data),
      .wa_be(wa_be),
      .wb_en(wb_en),
      .wb_addr(wb_addr),
      .wb_data(w.data[31:16]),
      .rlo_addr(rlo_addr),
      .rhi_addr(rhi_addr),
      .rdata(mem_rd)
   );

   // Read ports: bus and datapath
   for (genvar i = 0; i < NRD; i++) begin : g_rd
      wire [31:0] other_v =
         (rq[i].sel == CRF_PC) ? {12'h000, pc_q} :
         (rq[i].sel == CRF_VECTOR_TABLE_BASE) ? {12'h000, vector_table_base_q} :
         (rq[i].sel == CRF_USP) ? {16'h0000, usp_q} :
         (rq[i].sel == CRF_ISP) ? {16'h0000, isp_q} :
         (rq[i].sel == CRF_SB) ? {16'h0000, sb_q} :
         (rq[i].sel == CRF_SP) ? {16'h0000, use_usp ? usp_q : isp_q} :
         (rq[i].sel == CRF_FLG) ? {21'h000000, flg_q} : 32'h0000_0000;
      wire [15:0] lo = mem_rd[i][15:0];
      wire [15:0] hi = mem_rd[i][31:16];
      crf_sel_e hi_sel;
      assign hi_sel = pair_hi(rq[i].sel);
      assign rlo_addr[i] = {bank, rq[i].sel[2:0]};
      assign rhi_addr[i] = {bank, hi_sel[2:0]};
      assign rd_shaped[i] =
         !rq_q[i].en ? 32'h0000_0000 :
         !is_banked(rq_q[i].sel) ? other_q[i] :
         (rq_q[i].size == CRF_SZ_LO) ? {24'h000000, lo[7:0]} :
         (rq_q[i].size == CRF_SZ_HI) ? {24'h000000, lo[15:8]} :
         is_pair(rq_q[i].sel, rq_q[i].size) ? {hi, lo} :
         {16'h0000, lo};
      always_ff @(posedge clock) begin
         if (reset) begin
            rq_q[i] <= '0;
            other_q[i] <= '0;
         end else begin
            rq_q[i] <= rq[i];
            other_q[i] <= other_v;
         end
      end
   end
   assign reg_rdata = rd_shaped[0];
   assign dp_rdata = rd_shaped[1];

   // Arithmetic result flags by operand size
   wire alu_z = (alu.size == CRF_SZ_LONG) ? (alu.result == 32'h0000_0000) :
                (alu.size == CRF_SZ_WORD) ? (alu.result[15:0] == 16'h0000) :
                (alu.result[7:0] == 8'h00);
   wire alu_s = (alu.size == CRF_SZ_LONG) ? alu.result[31] :
                (alu.size == CRF_SZ_WORD) ? alu.result[15] : alu.result[7];
   wire trap_low = trap_exec && (trap_num < `CRF_TRAP_U_LIMIT);

   // Status word next value; interrupt clears take precedence
   always_comb begin
      flg_d = flg_q;
      if (w_flg) begin
         flg_d = w.data[`CRF_FLG_W-1:0];
      end
      if (alu.valid) begin
         flg_d[`CRF_F_C] = alu.carry;
         flg_d[`CRF_F_Z] = alu_z;
         flg_d[`CRF_F_S] = alu_s;
         flg_d[`CRF_F_O] = alu.ovf;
      end
      if (int_accept || trap_exec) begin
         flg_d[`CRF_F_I] = 1'b0;
      end
      if (int_accept || trap_low) begin
         flg_d[`CRF_F_U] = 1'b0;
      end
   end

   // Interrupt gate
   wire irq_ok = irq.req && (!irq.maskable || (int_en && (irq.prio > processor_priority_level)));

   always_ff @(posedge clock) begin
      if (reset) begin
         pc_q <= `CRF_PC_RST;
         vector_table_base_q <= `CRF_PC_RST;
         usp_q <= `CRF_WORD_RST;
         isp_q <= `CRF_WORD_RST;
         sb_q <= `CRF_WORD_RST;
         flg_q <= `CRF_FLG_RST;
         irq_allow_q <= 1'b0;
      end else begin
         if (w_pc) begin
            pc_q <= w.data[`CRF_PC_W-1:0];
         end
         if (w_vector_table_base) begin
            vector_table_base_q <= w.data[`CRF_PC_W-1:0];
         end
         if (w_usp) begin
            usp_q <= w.data[15:0];
         end
         if (w_isp) begin
            isp_q <= w.data[15:0];
         end
         if (w_sb) begin
            sb_q <= w.data[15:0];
         end
         flg_q <= flg_d;
         irq_allow_q <= irq_ok;
      end
   end
   assign irq_allow = irq_allow_q;
   assign status_word = flg_q;

   // Checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   a_u_clear_hw: assert property (
      int_accept |=> !flg_q[`CRF_F_U])
      else $error("stack select not cleared on interrupt accept");
   a_u_keep_trap: assert property (
      (trap_exec && !trap_low && !int_accept && !w_flg && use_usp) |=> flg_q[`CRF_F_U])
      else $error("stack select cleared by high trap number");
   a_i_clear_acc: assert property (
      (int_accept || trap_exec) |=> !flg_q[`CRF_F_I])
      else $error("interrupt enable not cleared on accept");
   a_mask_block: assert property (
      (irq.req && irq.maskable && !int_en) |=> !irq_allow)
      else $error("masked interrupt allowed");
   a_prio_gate: assert property (
      (irq.req && irq.maskable && int_en) |=> irq_allow == ($past(irq.prio) > $past(processor_priority_level)))
      else $error("priority comparison wrong");
   a_zero_word: assert property (
      (alu.valid && alu.size == CRF_SZ_WORD)
      |=> flg_q[`CRF_F_Z] == ($past(alu.result[15:0]) == 16'h0000))
      else $error("zero flag wrong");
   a_sign_long: assert property (
      (alu.valid && alu.size == CRF_SZ_LONG) |=> flg_q[`CRF_F_S] == $past(alu.result[31]))
      else $error("sign flag wrong");
   a_carry_ovf: assert property (
      alu.valid |=> flg_q[`CRF_F_C] == $past(alu.carry) && flg_q[`CRF_F_O] == $past(alu.ovf))
      else $error("carry or overflow flag wrong");
   a_sp_route: assert property (
      (w.en && w.sel == CRF_SP && !use_usp) |=> isp_q == $past(w.data[15:0]))
      else $error("stack write missed interrupt pointer");
   a_pc_read: assert property (
      (reg_rd && reg_addr == `CRF_ADDR_PC) |=> reg_rdata == {12'h000, $past(pc_q)})
      else $error("program counter read wrong");
   a_rd_idle: assert property (
      !reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data outside its cycle");
   a_pair_read: assert property (
      (dp_wr.en && dp_wr.sel == CRF_D0 && dp_wr.size == CRF_SZ_LONG
       ##1 !wa_en && !w_flg
       ##1 dp_rd.en && dp_rd.sel == CRF_D0 && dp_rd.size == CRF_SZ_LONG)
      |=> dp_rdata == $past(dp_wr.data, 3))
      else $error("data pair readback wrong");

   c_trap_low: cover property (trap_low && use_usp ##1 !use_usp);
   c_bank_swap: cover property ($rose(bank) ##[1:8] reg_rd);
   c_long_write: cover property (wb_en);
   c_irq_allow: cover property (irq.maskable && irq_allow);
endmodule : crf_regfile

// [dv/crf_exec_model.sv]
`timescale 1ns/1ps
module crf_exec_model
   import crf_pkg::*;
(
   // Clock
   input wire logic clock,
   // Datapath
   output crf_acc_s dp_wr,
   output crf_acc_s dp_rd,
   input wire logic [31:0] dp_rdata,
   output crf_alu_s alu,
   // Interrupt acceptance
   output crf_irq_s irq,
   output logic int_accept,
   output logic trap_exec,
   output logic [5:0] trap_num,
   input wire logic irq_allow
);
   initial begin
      dp_wr = '0;
      dp_rd = '0;
      alu = '0;
      irq = '0;
      int_accept = 1'b0;
      trap_exec = 1'b0;
      trap_num = 6'h00;
   end

   // Requests change after an edge and, except irq, drop at the taking edge
   task automatic dp_write(input crf_sel_e s, input crf_size_e z, input logic [31:0] d);
      @(posedge clock);
      dp_wr <= '{en: 1'b1, sel: s, size: z, data: d};
      @(posedge clock);
      dp_wr.en <= 1'b0;
      dp_wr.data <= ~d;
      #1;
   endtask : dp_write

   task automatic dp_read(input crf_sel_e s, input crf_size_e z, output logic [31:0] d);
      @(posedge clock);
      dp_rd <= '{en: 1'b1, sel: s, size: z, data: 32'h0000_0000};
      @(posedge clock);
      dp_rd.en <= 1'b0;
      #1 d = dp_rdata;
   endtask : dp_read

   task automatic alu_op(input logic c, input logic o, input crf_size_e z,
                         input logic [31:0] r);
      @(posedge clock);
      alu <= '{valid: 1'b1, carry: c, ovf: o, size: z, result: r};
      @(posedge clock);
      alu.valid <= 1'b0;
      alu.result <= ~r;
      #1;
   endtask : alu_op

   task automatic accept;
      @(posedge clock);
      int_accept <= 1'b1;
      @(posedge clock);
      int_accept <= 1'b0;
      #1;
   endtask : accept

   // Trap numbers span the full six bits
   task automatic trap(input logic [5:0] n);
      @(posedge clock);
      trap_exec <= 1'b1;
      trap_num <= n;
      @(posedge clock);
      trap_exec <= 1'b0;
      trap_num <= ~n;
      #1;
   endtask : trap

   task automatic probe(input logic m, input logic [2:0] p, output logic a);
      @(posedge clock);
      irq <= '{req: 1'b1, maskable: m, prio: p};
      @(posedge clock);
      #1 a = irq_allow;
   endtask : probe
endmodule : crf_exec_model

// [dv/cpu_register_file_flags_tb.sv]
`timescale 1ns/1ps
module cpu_register_file_flags_tb import crf_pkg::*;;
   logic clock;
   logic reset;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic [31:0] dp_rdata;
   crf_acc_s dp_wr;
   crf_acc_s dp_rd;
   crf_alu_s alu;
   crf_irq_s irq;
   logic int_accept;
   logic trap_exec;
   logic [5:0] trap_num;
   logic irq_allow;
   logic [10:0] status_word;
   int err_total;
   int samples_checked;
   int cycles;
   logic [31:0] v;
   logic a;

   crf_regfile i_crf_regfile (.clock(clock), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .dp_wr(dp_wr), .dp_rd(dp_rd), .dp_rdata(dp_rdata), .alu(alu), .irq(irq),
      .int_accept(int_accept), .trap_exec(trap_exec), .trap_num(trap_num),
      .irq_allow(irq_allow), .status_word(status_word));

   crf_exec_model i_crf_exec_model (.clock(clock), .dp_wr(dp_wr), .dp_rd(dp_rd),
      .dp_rdata(dp_rdata), .alu(alu), .irq(irq), .int_accept(int_accept),
      .trap_exec(trap_exec), .trap_num(trap_num), .irq_allow(irq_allow));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic bw(input logic [3:0] ad, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : bw

   task automatic rd_chk(input logic [3:0] ad, input logic [31:0] exp);
      @(posedge clock);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask : rd_chk

   task automatic t_reset;
      for (int i = 0; i < 16; i++) begin
         rd_chk(4'(i), 32'h0000_0000);
      end
   endtask : t_reset

   task automatic t_width;
      for (int i = 0; i < 13; i++) begin
         if (i != 7) begin
            bw(4'(i), 32'hFFFF_FFFF);
            rd_chk(4'(i), (i == 8 || i == 9) ? 32'h000F_FFFF : 32'h0000_FFFF);
         end
      end
      bw(4'h7, 32'hFFFF_FFFF);
      rd_chk(4'h7, 32'h0000_0000);
      bw(CRF_FLG, 32'h0000_07FD);
      rd_chk(CRF_FLG, 32'h0000_07FD);
      chk({21'h0, status_word}, 32'h0000_07FD);
      bw(CRF_FLG, 32'h0000_0000);
   endtask : t_width

   task automatic t_bank;
      bw(CRF_D0, 32'h0000_1111);
      bw(CRF_FLG, 32'h0000_0010);
      rd_chk(CRF_D0, 32'h0000_0000);
      rd_chk(CRF_FB, 32'h0000_0000);
      rd_chk(CRF_SB, 32'h0000_FFFF);
      bw(CRF_D0, 32'h0000_2222);
      bw(CRF_FLG, 32'h0000_0000);
      rd_chk(CRF_D0, 32'h0000_1111);
      bw(CRF_FLG, 32'h0000_0010);
      rd_chk(CRF_D0, 32'h0000_2222);
      bw(CRF_FLG, 32'h0000_0000);
   endtask : t_bank

   task automatic t_halves_pairs;
      i_crf_exec_model.dp_write(CRF_D1, CRF_SZ_HI, 32'h0000_00AB);
      i_crf_exec_model.dp_write(CRF_D1, CRF_SZ_LO, 32'h0000_00CD);
      rd_chk(CRF_D1, 32'h0000_ABCD);
      i_crf_exec_model.dp_read(CRF_D1, CRF_SZ_HI, v);
      chk(v, 32'h0000_00AB);
      i_crf_exec_model.dp_read(CRF_D1, CRF_SZ_LO, v);
      chk(v, 32'h0000_00CD);
      i_crf_exec_model.dp_write(CRF_D0, CRF_SZ_LONG, 32'h1234_5678);
      rd_chk(CRF_D2, 32'h0000_1234);
      rd_chk(CRF_D0, 32'h0000_5678);
      i_crf_exec_model.dp_write(CRF_D1, CRF_SZ_LONG, 32'h9ABC_DEF0);
      rd_chk(CRF_D3, 32'h0000_9ABC);
      rd_chk(CRF_D1, 32'h0000_DEF0);
      i_crf_exec_model.dp_write(CRF_A0, CRF_SZ_LONG, 32'h0BAD_F00D);
      rd_chk(CRF_A1, 32'h0000_0BAD);
      rd_chk(CRF_A0, 32'h0000_F00D);
      i_crf_exec_model.dp_read(CRF_D0, CRF_SZ_LONG, v);
      chk(v, 32'h1234_5678);
      i_crf_exec_model.dp_write(CRF_D0, CRF_SZ_LONG, 32'hC3C3_5A5A);
      i_crf_exec_model.dp_read(CRF_D0, CRF_SZ_LONG, v);
      chk(v, 32'hC3C3_5A5A);
   endtask : t_halves_pairs

   task automatic t_stack;
      bw(CRF_USP, 32'h0000_AAAA);
      bw(CRF_ISP, 32'h0000_5555);
      bw(CRF_FLG, 32'h0000_00C0);
      rd_chk(CRF_SP, 32'h0000_AAAA);
      i_crf_exec_model.accept();
      chk({21'h0, status_word}, 32'h0000_0000);
      rd_chk(CRF_SP, 32'h0000_5555);
      bw(CRF_SP, 32'h0000_1357);
      rd_chk(CRF_ISP, 32'h0000_1357);
      bw(CRF_FLG, 32'h0000_00C0);
      i_crf_exec_model.trap(6'h1F);
      chk({21'h0, status_word}, 32'h0000_0000);
      bw(CRF_FLG, 32'h0000_00C0);
      i_crf_exec_model.trap(6'h20);
      chk({21'h0, status_word}, 32'h0000_0080);
      bw(CRF_SP, 32'h0000_2468);
      rd_chk(CRF_USP, 32'h0000_2468);
      bw(CRF_FLG, 32'h0000_0000);
   endtask : t_stack

   task automatic flag_case(input logic c, input logic o, input crf_size_e z,
                            input logic [31:0] r, input logic [31:0] exp);
      i_crf_exec_model.alu_op(c, o, z, r);
      chk({21'h0, status_word}, exp);
   endtask : flag_case

   task automatic t_flags;
      flag_case(1'b1, 1'b0, CRF_SZ_WORD, 32'h0000_0000, 32'h0000_0005);
      flag_case(1'b0, 1'b1, CRF_SZ_WORD, 32'h0000_8000, 32'h0000_0028);
      flag_case(1'b0, 1'b0, CRF_SZ_LO, 32'h0000_0100, 32'h0000_0004);
      flag_case(1'b0, 1'b0, CRF_SZ_LONG, 32'h8000_0001, 32'h0000_0008);
      flag_case(1'b0, 1'b0, CRF_SZ_WORD, 32'h0001_0001, 32'h0000_0000);
   endtask : t_flags

   task automatic irq_case(input logic m, input logic [2:0] p, input logic exp);
      i_crf_exec_model.probe(m, p, a);
      chk({31'h0, a}, {31'h0, exp});
   endtask : irq_case

   task automatic t_irq;
      bw(CRF_FLG, 32'h0000_0340);
      irq_case(1'b1, 3'h3, 1'b0);
      irq_case(1'b1, 3'h4, 1'b1);
      bw(CRF_FLG, 32'h0000_0700);
      irq_case(1'b1, 3'h7, 1'b0);
      irq_case(1'b0, 3'h0, 1'b1);
      bw(CRF_FLG, 32'h0000_0040);
      irq_case(1'b1, 3'h0, 1'b0);
      irq_case(1'b1, 3'h1, 1'b1);
   endtask : t_irq

   task automatic end_sim;
      $display("checked %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         err_total++;
         end_sim();
      end
   end

   initial begin
      reset = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 32'h0000_0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      err_total = 0;
      samples_checked = 0;
      cycles = 0;
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      t_reset();
      t_width();
      t_bank();
      t_halves_pairs();
      t_stack();
      t_flags();
      t_irq();
      end_sim();
   end
endmodule : cpu_register_file_flags_tb
